// ===== rate_pkg.sv
// Purpose: Shared constants for the watch/standby rate selection block.
// Assumes: 40 MHz clock; rates are held in tenths of a hertz.
// Notes: Register offsets are word indices; the byte address is four times the index.
// Overview of operation
// [R01] 8-bit read/write rate control register at index 0x12, zero after reset.
// [R02] Software always writes zero to bit 4 between the two rate fields.
// [R03] Bits [3:0] pick the watch sample rate; 1101 and 1110 are unsupported.
// [R04] Bits [7:5] pick the standby clock rate, 000 slowest, 111 fastest.
// [R05] Power mode bits [6:4] of index 0x1C select which rate table applies.
// [R06] Table rates are approximate typical maximum rates, not exact frequencies.
// [R07] The all-ones watch code needs an extra software setup procedure.
// [R08] An unsupported code falls back to the default rate; ticks never stop.
package rate_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // Register map, word indices.
   localparam logic [5:0] RATE_CTRL_IDX = 6'h12;
   localparam logic [5:0] PMODE_IDX = 6'h1C;
   localparam logic [5:0] STATUS_IDX = 6'h20;
   localparam logic [7:0] RATE_CTRL_RESET = 8'h00;
   localparam logic [2:0] PMODE_RESET = 3'h0;
   // Field positions.
   localparam int WATCH_LSB = 0;
   localparam int ZERO_BIT = 4;
   localparam int STANDBY_LSB = 5;
   localparam int PMODE_LSB = 4;
   localparam int STATUS_FALLBACK_BIT = 8;
   // Power mode encodings.
   localparam logic [2:0] PM_ULP = 3'h3;
   localparam logic [2:0] PM_LP = 3'h0;
   localparam logic [2:0] PM_PREC = 3'h4;
   ////////////////////////////////////////////////////////////////////////////////
   // Timing: a rate in tenths of Hz is added each cycle; a tick fires at the limit.
   localparam int unsigned CLOCK_HZ = 40_000_000;
   localparam int unsigned RATE_SCALE = 10;
   localparam logic [31:0] TICK_LIMIT = 32'(CLOCK_HZ * RATE_SCALE);
   // Watch rates per code, tenths of Hz; zero marks an unsupported code.
   localparam logic [15:0] WATCH_ULP [16] = '{16'h003C, 16'h0004, 16'h0008, 16'h000F,
      16'h003C, 16'h0082, 16'h00FA, 16'h01F4, 16'h03E8, 16'h076C, 16'h0ED8, 16'h1D4C,
      16'h2AF8, 16'h0000, 16'h0000, 16'h32C8};
   localparam logic [15:0] WATCH_LP [16] = '{16'h0046, 16'h0004, 16'h0008, 16'h000F,
      16'h0046, 16'h008C, 16'h0118, 16'h021C, 16'h041A, 16'h0834, 16'h0FA0, 16'h1770,
      16'h0000, 16'h0000, 16'h0000, 16'h1D4C};
   localparam logic [15:0] WATCH_PREC [16] = '{16'h0046, 16'h0002, 16'h0004, 16'h0009,
      16'h0046, 16'h008C, 16'h0118, 16'h0226, 16'h0320, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h03E8};
   // Standby rates per code, tenths of Hz.
   localparam logic [15:0] STBY_ULP [8] = '{16'h000A, 16'h001E, 16'h0032, 16'h0064,
      16'h00E6, 16'h01C2, 16'h0384, 16'h0708};
   localparam logic [15:0] STBY_LP [8] = '{16'h0005, 16'h000A, 16'h001E, 16'h003C,
      16'h0078, 16'h00F0, 16'h01E0, 16'h03E8};
   localparam logic [15:0] STBY_PREC [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
      16'h000F, 16'h001E, 16'h0032, 16'h0064};
endpackage

// ===== rate_link_if.sv
// Purpose: Carries a rate increment to a tick generator and its tick back.
// Assumes: Both ends share one clock.
// Notes: One instance per generated rate.
interface rate_link_if;
   logic [15:0] inc;
   logic tick;
   modport gen (input inc, output tick);
   modport ctl (output inc, input tick);
endinterface

// ===== rate_tick_gen.sv
// Purpose: Phase accumulator that turns a rate in tenths of Hz into tick pulses.
// Assumes: Increment stays far below the limit, so ticks are never adjacent.
// Notes: Average rate is exact over time; single periods jitter by one cycle.
module rate_tick_gen
   import rate_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Rate link.
   rate_link_if.gen link
);
   typedef struct packed {
      logic [31:0] acc;
      logic tick;
   } gen_state_t;
   gen_state_t s_q, s_d;
   logic [32:0] sum;

   ////////////////////////////////////////////////////////////////////////////////
   // Accumulate; on crossing the limit, wrap and pulse. The wrap keeps the
   // remainder, so the long-run rate matches the table without a divider.
   always_comb begin
      s_d = s_q;
      sum = {1'b0, s_q.acc} + {17'h0_0000, link.inc};
      // [R06] approximate rate pacing
      if (sum >= {1'b0, TICK_LIMIT}) begin
         s_d.acc = 32'(sum - {1'b0, TICK_LIMIT});
         s_d.tick = 1'b1;
      end else begin
         s_d.acc = sum[31:0];
         s_d.tick = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.tick = s_q.tick;

   // Ticks are one-cycle pulses at any supported rate.
   property p_tick_pulse;
      @(posedge clock) disable iff (srst) s_q.tick |=> !s_q.tick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick lasted two cycles"); // [R06]
endmodule

// ===== watch_standby_rate_select.sv
// Purpose: Rate control register and watch/standby rate tick generation.
// Assumes: Avalon-MM slave with one wait state; byte addresses, word registers.
// Notes: Unsupported watch codes run at the default code's rate for the mode.
module watch_standby_rate_select
   import rate_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Avalon-MM slave.
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Rate ticks.
   output logic watch_tick,
   output logic standby_tick
);
   typedef struct packed {
      logic [3:0] watch_rate_code;
      logic [2:0] standby_rate_code;
      logic [2:0] pmode;
      logic [31:0] rdata;
      logic waitreq;
      logic watch_tick;
      logic standby_tick;
   } top_state_t;
   top_state_t s_q, s_d;

   rate_link_if watch_link();
   rate_link_if stby_link();

   logic [15:0] watch_raw;
   logic [15:0] stby_rate;
   logic fallback;
   logic req;
   logic take;
   logic [5:0] idx;
   logic [7:0] ctrl_rd;

   ////////////////////////////////////////////////////////////////////////////////
   // Rate lookup from code and power mode.
   always_comb begin
      // [R05] mode picks table
      case (s_q.pmode)
         PM_ULP: begin
            watch_raw = WATCH_ULP[s_q.watch_rate_code];
            stby_rate = STBY_ULP[s_q.standby_rate_code];
         end
         PM_PREC: begin
            watch_raw = WATCH_PREC[s_q.watch_rate_code];
            stby_rate = STBY_PREC[s_q.standby_rate_code];
         end
         default: begin
            watch_raw = WATCH_LP[s_q.watch_rate_code];
            stby_rate = STBY_LP[s_q.standby_rate_code];
         end
      endcase
   end

   // [R08] default rate fallback
   assign fallback = (watch_raw == 16'h0000);
   // [R03] watch code rate
   always_comb begin
      if (!fallback) begin
         watch_link.inc = watch_raw;
      end else if (s_q.pmode == PM_ULP) begin
         watch_link.inc = WATCH_ULP[0];
      end else if (s_q.pmode == PM_PREC) begin
         watch_link.inc = WATCH_PREC[0];
      end else begin
         watch_link.inc = WATCH_LP[0];
      end
   end
   // [R04] standby code rate
   assign stby_link.inc = stby_rate;

   rate_tick_gen u_watch_gen (
      .clock(clock),
      .srst(srst),
      .link(watch_link.gen)
   );

   rate_tick_gen u_stby_gen (
      .clock(clock),
      .srst(srst),
      .link(stby_link.gen)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode. A request is answered one cycle after it is seen, and takes
   // effect at the edge where waitrequest is low.
   assign req = read | write;
   assign take = req & !s_q.waitreq;
   assign idx = address[7:2];
   assign ctrl_rd = {s_q.standby_rate_code, 1'b0, s_q.watch_rate_code};

   always_comb begin
      s_d = s_q;
      s_d.watch_tick = watch_link.tick;
      s_d.standby_tick = stby_link.tick;
      // Waitrequest drops for one cycle after a request is first seen. It has a flop
      // of its own, high at rest, so the port needs no inverter after the register.
      s_d.waitreq = !(req & s_q.waitreq);
      // Read data is captured before the answer; unmapped reads return zero.
      if (read && s_q.waitreq) begin
         case (idx)
            RATE_CTRL_IDX: s_d.rdata = {24'h00_0000, ctrl_rd};
            PMODE_IDX: s_d.rdata = {25'h000_0000, s_q.pmode, 4'h0};
            STATUS_IDX: s_d.rdata = {23'h00_0000, fallback, ctrl_rd};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      // [R01] register write
      if (take && write && byteenable[0]) begin
         case (idx)
            RATE_CTRL_IDX: begin
               // Bit 4 is not stored, so it always reads back as zero.
               s_d.watch_rate_code = writedata[WATCH_LSB +: 4];
               s_d.standby_rate_code = writedata[STANDBY_LSB +: 3];
            end
            PMODE_IDX: s_d.pmode = writedata[PMODE_LSB +: 3];
            default: s_d.pmode = s_q.pmode;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s_q.watch_rate_code <= RATE_CTRL_RESET[WATCH_LSB +: 4];
         s_q.standby_rate_code <= RATE_CTRL_RESET[STANDBY_LSB +: 3];
         s_q.pmode <= PMODE_RESET;
         s_q.rdata <= 32'h0000_0000;
         s_q.waitreq <= 1'b1;
         s_q.watch_tick <= 1'b0;
         s_q.standby_tick <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign readdata = s_q.rdata;
   assign waitrequest = s_q.waitreq;
   assign watch_tick = s_q.watch_tick;
   assign standby_tick = s_q.standby_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_ctrl_write;
      @(posedge clock) disable iff (srst)
         (write && !waitrequest && byteenable[0] && idx == RATE_CTRL_IDX)
         |=> ctrl_rd == {$past(writedata[7:5]), 1'b0, $past(writedata[3:0])};
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // [R01]

   property p_ctrl_read;
      @(posedge clock) disable iff (srst)
         (read && !waitrequest && idx == RATE_CTRL_IDX) |-> readdata == {24'h00_0000, ctrl_rd};
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong"); // [R01]

   property p_watch_top;
      @(posedge clock) disable iff (srst)
         (s_q.pmode == PM_ULP && s_q.watch_rate_code == 4'hF) |-> watch_link.inc == 16'h32C8;
   endproperty
   a_watch_top: assert property (p_watch_top) else $error("watch rate wrong"); // [R03]

   property p_stby_fast;
      @(posedge clock) disable iff (srst)
         (s_q.pmode == PM_ULP && s_q.standby_rate_code == 3'h7) |-> stby_link.inc == 16'h0708;
   endproperty
   a_stby_fast: assert property (p_stby_fast) else $error("standby rate wrong"); // [R04]

   property p_prec_mode;
      @(posedge clock) disable iff (srst)
         (s_q.pmode == PM_PREC && s_q.standby_rate_code == 3'h0) |-> stby_link.inc == 16'h0001;
   endproperty
   a_prec_mode: assert property (p_prec_mode) else $error("mode table wrong"); // [R05]

   property p_fallback;
      @(posedge clock) disable iff (srst)
         (s_q.watch_rate_code == 4'hD) |-> fallback && watch_link.inc != 16'h0000;
   endproperty
   a_fallback: assert property (p_fallback) else $error("unsupported code stalls"); // [R08]

   property p_answer;
      @(posedge clock) disable iff (srst)
         (req && waitrequest) |=> !waitrequest ##1 waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer timing wrong"); // [R01]

   property p_tick_out;
      @(posedge clock) disable iff (srst) watch_tick |=> !watch_tick;
   endproperty
   a_tick_out: assert property (p_tick_out) else $error("watch tick too long"); // [R06]

   // [R01] reset state check
   property p_reset_idle;
      @(posedge clock) srst |=> waitrequest && !watch_tick && !standby_tick
         && readdata == 32'h0000_0000 && ctrl_rd == RATE_CTRL_RESET && s_q.pmode == PMODE_RESET;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("reset state wrong"); // [R01]

   // [R08] precision default rate
   property p_prec_dflt;
      @(posedge clock) disable iff (srst)
         (fallback && s_q.pmode == PM_PREC) |-> watch_link.inc == 16'h0046;
   endproperty
   a_prec_dflt: assert property (p_prec_dflt) else $error("fallback rate wrong"); // [R08]

   // [R03] low power table
   property p_lp_watch;
      @(posedge clock) disable iff (srst)
         (s_q.pmode == PM_LP && s_q.watch_rate_code == 4'hB) |-> watch_link.inc == 16'h1770;
   endproperty
   a_lp_watch: assert property (p_lp_watch) else $error("low power watch rate wrong"); // [R03]

   c_ctrl_write: cover property (@(posedge clock) take && write && idx == RATE_CTRL_IDX);
   c_fallback: cover property (@(posedge clock) fallback);
   c_stby_tick: cover property (@(posedge clock) standby_tick);
   c_watch_tick: cover property (@(posedge clock) watch_tick);
endmodule

// ===== watch_standby_rate_select_tb.sv
// Purpose: Self-checking bench for the watch/standby rate selection block.
// Assumes: Avalon-MM slave answering after one wait cycle; 40 MHz clock.
// Notes: Tick timing is measured only at the fastest watch code to keep the run short.
module watch_standby_rate_select_tb
   import rate_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, reset and bus drive.
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitrequest;
   logic watch_tick;
   logic standby_tick;
   int error_cnt = 0;
   int n_checks = 0;
   logic [7:0] ctrl_m;
   logic [31:0] q;
   logic [31:0] d;
   logic [3:0] be;
   int n;
   int sb;
   localparam logic [7:0] A_CTRL = {RATE_CTRL_IDX, 2'b00};
   localparam logic [7:0] A_PM = {PMODE_IDX, 2'b00};
   localparam logic [7:0] A_STAT = {STATUS_IDX, 2'b00};
   localparam logic [2:0] MODES [3] = '{PM_ULP, PM_LP, PM_PREC};

   // The half period flips the clock for a 25 ns cycle.
   always #12.5 clock = ~clock;

   watch_standby_rate_select DUT (.clock(clock), .srst(srst), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .watch_tick(watch_tick),
      .standby_tick(standby_tick));
   ////////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus tasks.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One edge passes first, so a release and a new request never share a time step.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] ben, output logic [31:0] rd);
      int k;
      k = 0;
      @(posedge clock);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= wd;
      byteenable <= ben;
      do begin
         @(posedge clock);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // A bus that never answers ends the run as a failure.
      if (k >= 50) begin
         error_cnt++;
         summarize();
      end
   endtask

   // Expected fallback flag: code not listed for the selected power mode.
   function automatic logic unsup(input logic [2:0] pm, input logic [3:0] c);
      if (c == 4'hD || c == 4'hE) return 1'b1;
      if (pm == PM_ULP) return 1'b0;
      if (pm == PM_PREC) return (c >= 4'h9 && c != 4'hF);
      return (c == 4'hC);
   endfunction

   task automatic do_reset();
      srst <= 1'b1;
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      ctrl_m = 8'h00;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      void'($urandom(32));
      do_reset();
      bus(1'b0, A_CTRL, 32'h0000_0000, 4'hF, q);
      check(q, 32'h0000_0000);
      bus(1'b0, A_PM, 32'h0000_0000, 4'hF, q);
      check(q, 32'h0000_0000);
      $display("test reset_values done");
      // Random writes, some with the low byte disabled; bit 4 is always sent as zero.
      for (int i = 0; i < 12; i++) begin
         d = ((i == 0) ? 32'hFFFF_FFFF : $urandom) & 32'hFFFF_FFEF;
         be = (i == 0) ? 4'h1 : 4'($urandom);
         bus(1'b1, A_CTRL, d, be, q);
         if (be[0]) ctrl_m = d[7:0] & 8'hEF;
         bus(1'b0, A_CTRL, 32'h0000_0000, 4'hF, q);
         check(q, {24'h00_0000, ctrl_m});
      end
      // Unmapped place: writes ignored, reads zero.
      bus(1'b1, 8'h4C, 32'h0000_00FF, 4'hF, q);
      bus(1'b0, 8'h4C, 32'h0000_0000, 4'hF, q);
      check(q, 32'h0000_0000);
      $display("test rw_random done");
      // Every watch code in every mode, with a random standby field beside it.
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, A_PM, {25'h0, MODES[m], 4'h0}, 4'h1, q);
         bus(1'b0, A_PM, 32'h0000_0000, 4'hF, q);
         check(q, {25'h0, MODES[m], 4'h0});
         for (int c = 0; c < 16; c++) begin
            ctrl_m = {3'($urandom), 1'b0, 4'(c)};
            bus(1'b1, A_CTRL, {24'h00_0000, ctrl_m}, 4'h1, q);
            bus(1'b0, A_STAT, 32'h0000_0000, 4'hF, q);
            check(q, {23'h0, unsup(MODES[m], 4'(c)), ctrl_m});
         end
      end
      $display("test mode_codes done");
      // Fastest watch code: 1300 Hz gives 400000000/13000 cycles, one cycle of jitter.
      // The fastest standby code, 180 Hz, needs far more cycles than this run has.
      bus(1'b1, A_PM, {25'h0, PM_ULP, 4'h0}, 4'h1, q);
      bus(1'b1, A_CTRL, 32'h0000_00EF, 4'h1, q);
      n = 0;
      sb = 0;
      do begin
         @(posedge clock);
         n++;
         sb += int'(standby_tick === 1'b1);
      end while (watch_tick !== 1'b1 && n < 40000);
      check(32'(n < 40000), 32'h0000_0001);
      @(posedge clock);
      check(32'(watch_tick), 32'h0000_0000);
      n = 1;
      do begin
         @(posedge clock);
         n++;
         sb += int'(standby_tick === 1'b1);
      end while (watch_tick !== 1'b1 && n < 40000);
      check(32'(n >= 30769 && n <= 30770), 32'h0000_0001);
      check(32'(sb), 32'h0000_0000);
      $display("test tick_period done");
      // A second reset in mid-run clears both registers again.
      bus(1'b1, A_CTRL, 32'h0000_00EB, 4'h1, q);
      @(posedge clock);
      do_reset();
      bus(1'b0, A_CTRL, 32'h0000_0000, 4'hF, q);
      check(q, 32'h0000_0000);
      bus(1'b0, A_PM, 32'h0000_0000, 4'hF, q);
      check(q, 32'h0000_0000);
      $display("test mid_reset done");
      summarize();
   end
endmodule
